// ==== hw/lvd_pkg.sv ====
// constants shared by the low-voltage detector control logic
package lvd_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] LEVEL_OFS = 8'h04;
  localparam logic [7:0] CAUSE_OFS = 8'h08;
  localparam logic [7:0] IRQ_OFS   = 8'h0C;
  localparam logic [7:0] PDIR_OFS  = 8'h10;
  localparam logic [7:0] PORT_OFS  = 8'h14;
  localparam logic [7:0] STAT_OFS  = 8'h18;

  // decoded register index
  localparam logic [2:0] SEL_CTRL  = 3'h0;
  localparam logic [2:0] SEL_LEVEL = 3'h1;
  localparam logic [2:0] SEL_CAUSE = 3'h2;
  localparam logic [2:0] SEL_IRQ   = 3'h3;
  localparam logic [2:0] SEL_PDIR  = 3'h4;
  localparam logic [2:0] SEL_PORT  = 3'h5;
  localparam logic [2:0] SEL_STAT  = 3'h6;
  localparam logic [2:0] SEL_NONE  = 3'h7;

  // field positions
  localparam int unsigned FLAG_BIT    = 0;
  localparam int unsigned ACT_BIT     = 1;
  localparam int unsigned SRC_BIT     = 2;
  localparam int unsigned ON_BIT      = 7;
  localparam int unsigned LEVEL_MSB   = 3;
  localparam int unsigned CAUSE_BIT   = 0;
  localparam int unsigned REQ_BIT     = 0;
  localparam int unsigned MASK_BIT    = 1;
  localparam int unsigned PIN_BIT     = 0;
  localparam int unsigned PORT_IN_BIT = 1;
  localparam int unsigned SETTLED_BIT = 0;

  // reset values
  localparam logic [7:0] PDIR_RST  = 8'hFF;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic       MASK_RST  = 1'b1;

  // comparator settling time, rounded up to whole clocks
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned STAB_TIME_US  = 10;
  localparam int unsigned STAB_W        = 11;
  localparam logic [STAB_W-1:0] STAB_CYC = STAB_W'(
    (STAB_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

endpackage : lvd_pkg

// ==== hw/lvd_sync_if.sv ====
// carrier between an asynchronous level and its synchroniser
`timescale 1ns/1ps
interface lvd_sync_if;
  logic raw;
  logic level;
  modport filt (input raw, output level);
  modport user (output raw, input level);
endinterface : lvd_sync_if

// ==== hw/lvd_sync.sv ====
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module lvd_sync (
  input  wire logic  clk,
  input  wire logic  reset,
  lvd_sync_if.filt   port
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_t;

  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = port.raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change counts only once two settled stages agree
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port.level = st.level;

  sync_follow_a: assert property (@(posedge clk) disable iff (reset)
    (st.s2 == st.s3) |=> (st.level == $past(st.s3)))
    else $error("synchronised level missed an agreed change");

endmodule : lvd_sync

// ==== hw/lvd_ctrl.sv ====
// low-voltage detector control with APB register file
// Operation
// - every reset loads the pin direction register with all ones.
// - direction bit 0 drives the pin, 1 turns the output buffer off.
// - reset mode on supply: reset held while supply below threshold.
// - reset mode on external pin: reset held while input below reference.
// - interrupt mode on supply: interrupt on each threshold crossing.
// - interrupt mode on external pin: interrupt on each crossing.
// - below-level flag sits in control bit 0 while detector runs.
// - action select is control bit 1, source select bit 2.
// - writing 1 to control bit 7 turns the detector on.
// - arming reset while voltage is above gives no reset.
// - switching off while below in interrupt mode raises the interrupt and request.
// - every reset, detector reset too, sets the interrupt mask.
// - level code bits 3..0 choose the supply threshold.
// - a detector reset sets the reset cause bit.
// - enable, action and source survive only a detector reset.
// - level register survives only a detector reset.
`timescale 1ns/1ps
module lvd_ctrl (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CMP_BELOW,
  output logic             DET_ENABLE,
  output logic             SRC_SELECT,
  output logic      [3:0]  LEVEL_CODE,
  output logic             LV_RESET,
  output logic             LV_IRQ,
  output logic             IRQ_PENDING,
  input  wire logic        PIN_IN,
  output logic             PIN_OUT,
  output logic             PIN_OE_N
);

  typedef struct packed {
    logic                      on;
    logic                      act;
    logic                      src;
    logic                      flag;
    logic [3:0]                level;
    logic                      cause;
    logic                      req;
    logic                      mask;
    logic [7:0]                pdir;
    logic                      platch;
    logic                      irq;
    logic                      lvrst;
    logic [lvd_pkg::STAB_W-1:0] stab;
    logic [31:0]               prdata;
  } ctrl_t;

  ctrl_t st;
  ctrl_t next_st;

  lvd_sync_if cmp_if ();
  lvd_sync_if pin_if ();

  assign cmp_if.raw = CMP_BELOW;
  assign pin_if.raw = PIN_IN;

  // comparator output is analog-timed, never used raw
  lvd_sync u_cmp_sync (
    .clk   (CLK),
    .reset (RESET),
    .port  (cmp_if.filt)
  );

  lvd_sync u_pin_sync (
    .clk   (CLK),
    .reset (RESET),
    .port  (pin_if.filt)
  );

  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] sel;
    sel = lvd_pkg::SEL_NONE;
    case (addr)
      lvd_pkg::CTRL_OFS:  sel = lvd_pkg::SEL_CTRL;
      lvd_pkg::LEVEL_OFS: sel = lvd_pkg::SEL_LEVEL;
      lvd_pkg::CAUSE_OFS: sel = lvd_pkg::SEL_CAUSE;
      lvd_pkg::IRQ_OFS:   sel = lvd_pkg::SEL_IRQ;
      lvd_pkg::PDIR_OFS:  sel = lvd_pkg::SEL_PDIR;
      lvd_pkg::PORT_OFS:  sel = lvd_pkg::SEL_PORT;
      lvd_pkg::STAT_OFS:  sel = lvd_pkg::SEL_STAT;
      default:            sel = lvd_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : reg_sel

  logic [2:0] sel;
  logic       wr;
  logic       rd_setup;
  logic       rd_done;
  logic       settled;

  assign sel      = reg_sel(PADDR);
  assign wr       = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign rd_done  = PSEL & PENABLE & ~PWRITE;
  assign settled  = (st.stab == lvd_pkg::STAB_CYC);

  always_comb begin
    next_st = st;

    // read data is caught in setup so it leaves a flop
    if (rd_setup) begin
      next_st.prdata = '0;
      case (sel)
        lvd_pkg::SEL_CTRL: begin
          next_st.prdata[lvd_pkg::ON_BIT]   = st.on;
          next_st.prdata[lvd_pkg::SRC_BIT]  = st.src;
          next_st.prdata[lvd_pkg::ACT_BIT]  = st.act;
          next_st.prdata[lvd_pkg::FLAG_BIT] = st.flag;
        end
        lvd_pkg::SEL_LEVEL: begin
          next_st.prdata[lvd_pkg::LEVEL_MSB:0] = st.level;
        end
        lvd_pkg::SEL_CAUSE: begin
          next_st.prdata[lvd_pkg::CAUSE_BIT] = st.cause;
        end
        lvd_pkg::SEL_IRQ: begin
          next_st.prdata[lvd_pkg::REQ_BIT]  = st.req;
          next_st.prdata[lvd_pkg::MASK_BIT] = st.mask;
        end
        lvd_pkg::SEL_PDIR: begin
          next_st.prdata[7:0] = st.pdir;
        end
        lvd_pkg::SEL_PORT: begin
          next_st.prdata[lvd_pkg::PIN_BIT]     = st.platch;
          next_st.prdata[lvd_pkg::PORT_IN_BIT] = pin_if.level;
        end
        lvd_pkg::SEL_STAT: begin
          next_st.prdata[lvd_pkg::SETTLED_BIT] = settled;
        end
        default: begin
          next_st.prdata = '0;
        end
      endcase
    end

    if (wr) begin
      case (sel)
        lvd_pkg::SEL_CTRL: begin
          // flag bit is read-only, writes to it are dropped
          next_st.on  = PWDATA[lvd_pkg::ON_BIT];
          next_st.src = PWDATA[lvd_pkg::SRC_BIT];
          next_st.act = PWDATA[lvd_pkg::ACT_BIT];
        end
        lvd_pkg::SEL_LEVEL: begin
          next_st.level = PWDATA[lvd_pkg::LEVEL_MSB:0];
        end
        lvd_pkg::SEL_IRQ: begin
          next_st.req  = PWDATA[lvd_pkg::REQ_BIT];
          next_st.mask = PWDATA[lvd_pkg::MASK_BIT];
        end
        lvd_pkg::SEL_PDIR: begin
          next_st.pdir = PWDATA[7:0];
        end
        lvd_pkg::SEL_PORT: begin
          next_st.platch = PWDATA[lvd_pkg::PIN_BIT];
        end
        default: begin
          next_st.pdir = next_st.pdir;
        end
      endcase
    end

    // reading the cause register clears it; only a set bit that the
    // read returned is cleared, so a set during setup is not lost
    if (rd_done && sel == lvd_pkg::SEL_CAUSE &&
        st.prdata[lvd_pkg::CAUSE_BIT]) begin
      next_st.cause = 1'b0;
    end

    // flag follows the comparator only while running
    next_st.flag = next_st.on & cmp_if.level;

    // any crossing in interrupt mode, including the drop
    // caused by switching off while below
    next_st.irq = (next_st.flag != st.flag) & ~st.act;
    // enabling unmasked while below fires at once
    if (next_st.irq) begin
      next_st.req = 1'b1;
    end

    // no reset unless already below, so arming above is safe
    next_st.lvrst = st.on & st.act & st.flag;

    // detector reset keeps control and level, as a
    // reset from elsewhere comes in on RESET instead
    if (st.lvrst) begin
      next_st.mask  = lvd_pkg::MASK_RST;
      next_st.cause = 1'b1;
      next_st.pdir  = lvd_pkg::PDIR_RST;
      next_st.req   = next_st.irq;
    end

    // settling count restarts on every enable
    if (!next_st.on) begin
      next_st.stab = '0;
    end else if (!settled) begin
      next_st.stab = st.stab + 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st        <= '0;
      st.level  <= lvd_pkg::LEVEL_RST;
      st.mask   <= lvd_pkg::MASK_RST;
      st.pdir   <= lvd_pkg::PDIR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA      = st.prdata;
  assign PREADY      = 1'b1;
  assign PSLVERR     = PSEL & PENABLE & (sel == lvd_pkg::SEL_NONE);
  assign DET_ENABLE  = st.on;
  assign SRC_SELECT  = st.src;
  assign LEVEL_CODE  = st.level;
  assign LV_RESET    = st.lvrst;
  assign LV_IRQ      = st.irq;
  assign IRQ_PENDING = st.req & ~st.mask;
  assign PIN_OUT     = st.platch;
  // external sensing needs this bit at 1, buffer off
  assign PIN_OE_N    = st.pdir[lvd_pkg::PIN_BIT];

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence below_armed;
    st.on && st.act && st.flag;
  endsequence

  sequence off_while_below;
    st.on && st.flag && !st.act ##1 !st.on;
  endsequence

  sequence ctrl_write;
    wr && sel == lvd_pkg::SEL_CTRL;
  endsequence

  rst_below_a: assert property (below_armed |=> LV_RESET)
    else $error("reset not raised while below threshold");

  rst_above_a: assert property (!st.flag |=> !LV_RESET)
    else $error("reset raised while at or above threshold");

  irq_cross_a: assert property (
    $changed(st.flag) && !$past(st.act) |-> LV_IRQ)
    else $error("crossing gave no interrupt");

  irq_quiet_a: assert property (
    $stable(st.flag) |-> !LV_IRQ)
    else $error("interrupt without a crossing");

  noirq_act_a: assert property (
    $past(st.act) |-> !LV_IRQ)
    else $error("interrupt raised in reset mode");

  irq_req_a: assert property (
    LV_IRQ |-> st.req)
    else $error("interrupt left the request clear");

  req_clr_a: assert property (
    wr && sel == lvd_pkg::SEL_IRQ && !LV_RESET |=>
      st.req == ($past(PWDATA[lvd_pkg::REQ_BIT]) || LV_IRQ))
    else $error("request clear beat a new crossing");

  off_below_a: assert property (
    off_while_below |-> LV_IRQ && st.req)
    else $error("switch off while below lost interrupt");

  flag_off_a: assert property (!DET_ENABLE |-> !st.flag)
    else $error("flag set while detector off");

  flag_cmp_a: assert property (
    st.flag == (st.on && $past(cmp_if.level)))
    else $error("flag does not follow the synchronised level");

  flag_rd_a: assert property (
    rd_setup && sel == lvd_pkg::SEL_CTRL |=>
      PRDATA[lvd_pkg::FLAG_BIT] == $past(st.flag))
    else $error("control read lost the below-level flag");

  stab_off_a: assert property (!DET_ENABLE |-> st.stab == '0)
    else $error("settling count not cleared while off");

  mask_rst_a: assert property (
    LV_RESET |=> st.mask && st.cause)
    else $error("detector reset left mask or cause clear");

  cause_rd_a: assert property (
    rd_done && sel == lvd_pkg::SEL_CAUSE &&
      PRDATA[lvd_pkg::CAUSE_BIT] && !LV_RESET |=> !st.cause)
    else $error("reading the cause bit did not clear it");

  keep_ctrl_a: assert property (
    LV_RESET && !wr |=> $stable(st.level) && $stable(st.src))
    else $error("detector reset disturbed settings");

  pdir_rst_a: assert property (
    LV_RESET |=> st.pdir == lvd_pkg::PDIR_RST)
    else $error("pin direction not all inputs after reset");

  oe_dir_a: assert property (
    wr && sel == lvd_pkg::SEL_PDIR && !LV_RESET |=>
      PIN_OE_N == $past(PWDATA[lvd_pkg::PIN_BIT]))
    else $error("pin buffer does not follow direction bit");

  pin_out_a: assert property (
    wr && sel == lvd_pkg::SEL_PORT |=>
      PIN_OUT == $past(PWDATA[lvd_pkg::PIN_BIT]))
    else $error("output latch did not take the written value");

  ctrl_wr_a: assert property (
    ctrl_write |=> DET_ENABLE == $past(PWDATA[lvd_pkg::ON_BIT]))
    else $error("enable bit did not take the written value");

  src_wr_a: assert property (
    ctrl_write |=> SRC_SELECT == $past(PWDATA[lvd_pkg::SRC_BIT]) &&
      st.act == $past(PWDATA[lvd_pkg::ACT_BIT]))
    else $error("source or action bit did not take the write");

  level_wr_a: assert property (
    wr && sel == lvd_pkg::SEL_LEVEL |=>
      LEVEL_CODE == $past(PWDATA[lvd_pkg::LEVEL_MSB:0]))
    else $error("level code did not take the written value");

endmodule : lvd_ctrl

// ==== tb/lvd_partner.sv ====
// comparator and shared-pin model facing the detector control
`timescale 1ns/1ps
module lvd_partner (
  input  wire logic       clk,
  input  wire logic       det_enable,
  input  wire logic       src_select,
  input  wire logic [3:0] level_code,
  input  wire logic [3:0] supply_step,
  input  wire logic       ext_below,
  input  wire logic       pin_out,
  input  wire logic       pin_oe_n,
  output logic            cmp_below,
  output logic            pin_in
);
  logic idle_pat = 1'b0;
  // a stopped comparator has no defined output, so it toggles
  always @(posedge clk) idle_pat <= ~idle_pat;
  // step s lies just above threshold s: below every code under s
  assign cmp_below = !det_enable ? idle_pat :
                     src_select ? ext_below :
                     (level_code < supply_step);
  // sense level only reaches the input while the buffer is off
  assign pin_in = pin_oe_n ? ~ext_below : pin_out;
endmodule : lvd_partner

// ==== tb/lvd_ctrl_tb_top.sv ====
// register-level bench for the low-voltage detector control
`timescale 1ns/1ps
module automatic lvd_ctrl_tb_top;
  logic        CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  logic        CMP_BELOW, DET_ENABLE, SRC_SELECT, LV_RESET, LV_IRQ;
  logic        IRQ_PENDING, PIN_IN, PIN_OUT, PIN_OE_N, ext_below, last_err;
  logic [3:0]  LEVEL_CODE, supply_step;
  int          bad_count, tests_run, irq_n, irq0;

  lvd_ctrl u_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CMP_BELOW(CMP_BELOW), .DET_ENABLE(DET_ENABLE),
    .SRC_SELECT(SRC_SELECT), .LEVEL_CODE(LEVEL_CODE), .LV_RESET(LV_RESET),
    .LV_IRQ(LV_IRQ), .IRQ_PENDING(IRQ_PENDING), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N));

  lvd_partner u_far (.clk(CLK), .det_enable(DET_ENABLE),
    .src_select(SRC_SELECT), .level_code(LEVEL_CODE),
    .supply_step(supply_step), .ext_below(ext_below), .pin_out(PIN_OUT),
    .pin_oe_n(PIN_OE_N), .cmp_below(CMP_BELOW), .pin_in(PIN_IN));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  always @(posedge CLK) if (LV_IRQ === 1'b1) irq_n <= irq_n + 1;

  task test_done;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task chk(input string name, input logic [31:0] exp,
           input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= is_wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    rdata = PRDATA;
    last_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // one idle edge, so the next setup never overwrites this release
    @(posedge CLK);
    if (n == 50) begin
      bad_count++;
      test_done;
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rc(input string name, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, e, rdata);
  endtask : rc

  // waits for the settled flag rather than a fixed delay
  task settle;
    int k;
    for (k = 0; k < 3000; k++) begin
      apb(1'b0, lvd_pkg::STAT_OFS, 32'h0);
      if (rdata[0] === 1'b1) break;
    end
    if (k == 3000) begin
      bad_count++;
      test_done;
    end
  endtask : settle

  task step(input logic [3:0] s, input logic e);
    supply_step <= s;
    ext_below <= e;
    repeat (10) @(posedge CLK);
  endtask : step

  initial begin
    repeat (60000) @(posedge CLK);
    bad_count++;
    test_done;
  end

  initial begin
    RESET <= 1'b1;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PWRITE <= 1'b0;
    PADDR <= 8'h00;
    PWDATA <= 32'h0;
    supply_step <= 4'h3;
    ext_below <= 1'b0;
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    chk("oe_n", 32'h1, PIN_OE_N);
    rc("pdir", lvd_pkg::PDIR_OFS, 32'hFF);
    rc("irq", lvd_pkg::IRQ_OFS, 32'h2);
    rc("ctrl", lvd_pkg::CTRL_OFS, 32'h0);
    rc("level", lvd_pkg::LEVEL_OFS, 32'h0);
    rc("unmapped", 8'h1C, 32'h0);
    chk("slverr", 32'h1, last_err);
    wr(lvd_pkg::PDIR_OFS, 32'hFE);
    wr(lvd_pkg::PORT_OFS, 32'h1);
    chk("pin_out", 32'h1, PIN_OUT);
    // far side pulls the pin low, so a high read proves the buffer drives
    step(4'h3, 1'b1);
    chk("oe_n", 32'h0, PIN_OE_N);
    rc("port", lvd_pkg::PORT_OFS, 32'h3);
    wr(lvd_pkg::PDIR_OFS, 32'hFF);
    step(4'h3, 1'b1);
    rc("port", lvd_pkg::PORT_OFS, 32'h1);
    wr(lvd_pkg::LEVEL_OFS, 32'h5);
    wr(lvd_pkg::IRQ_OFS, 32'h2);
    chk("code", 32'h5, LEVEL_CODE);
    wr(lvd_pkg::CTRL_OFS, 32'h80);
    settle;
    chk("on", 32'h1, DET_ENABLE);
    rc("ctrl", lvd_pkg::CTRL_OFS, 32'h80);
    wr(lvd_pkg::IRQ_OFS, 32'h0);
    irq0 = irq_n;
    step(4'h7, 1'b0);
    chk("irqs", 32'(irq0 + 1), 32'(irq_n));
    rc("ctrl", lvd_pkg::CTRL_OFS, 32'h81);
    rc("irq", lvd_pkg::IRQ_OFS, 32'h1);
    chk("pend", 32'h1, IRQ_PENDING);
    step(4'h3, 1'b0);
    chk("irqs", 32'(irq0 + 2), 32'(irq_n));
    step(4'h7, 1'b0);
    wr(lvd_pkg::IRQ_OFS, 32'h0);
    wr(lvd_pkg::CTRL_OFS, 32'h0);
    step(4'h7, 1'b0);
    chk("irqs", 32'(irq0 + 4), 32'(irq_n));
    rc("irq", lvd_pkg::IRQ_OFS, 32'h1);
    step(4'h3, 1'b0);
    wr(lvd_pkg::IRQ_OFS, 32'h2);
    wr(lvd_pkg::CTRL_OFS, 32'h84);
    settle;
    wr(lvd_pkg::IRQ_OFS, 32'h0);
    chk("src", 32'h1, SRC_SELECT);
    irq0 = irq_n;
    step(4'h3, 1'b1);
    chk("irqs", 32'(irq0 + 1), 32'(irq_n));
    rc("ctrl", lvd_pkg::CTRL_OFS, 32'h85);
    step(4'h3, 1'b0);
    chk("irqs", 32'(irq0 + 2), 32'(irq_n));
    wr(lvd_pkg::CTRL_OFS, 32'h0);
    wr(lvd_pkg::PDIR_OFS, 32'h0);
    wr(lvd_pkg::IRQ_OFS, 32'h2);
    wr(lvd_pkg::CTRL_OFS, 32'h80);
    settle;
    rc("ctrl", lvd_pkg::CTRL_OFS, 32'h80);
    wr(lvd_pkg::CTRL_OFS, 32'h82);
    step(4'h3, 1'b0);
    chk("lv_reset", 32'h0, LV_RESET);
    step(4'h7, 1'b0);
    chk("lv_reset", 32'h1, LV_RESET);
    rc("ctrl", lvd_pkg::CTRL_OFS, 32'h83);
    rc("level", lvd_pkg::LEVEL_OFS, 32'h5);
    rc("pdir", lvd_pkg::PDIR_OFS, 32'hFF);
    rc("cause", lvd_pkg::CAUSE_OFS, 32'h1);
    wr(lvd_pkg::IRQ_OFS, 32'h0);
    rc("irq", lvd_pkg::IRQ_OFS, 32'h2);
    step(4'h3, 1'b0);
    chk("lv_reset", 32'h0, LV_RESET);
    wr(lvd_pkg::CTRL_OFS, 32'h80);
    wr(lvd_pkg::CTRL_OFS, 32'h0);
    wr(lvd_pkg::CTRL_OFS, 32'h84);
    settle;
    wr(lvd_pkg::CTRL_OFS, 32'h86);
    step(4'h3, 1'b1);
    chk("lv_reset", 32'h1, LV_RESET);
    step(4'h3, 1'b0);
    chk("lv_reset", 32'h0, LV_RESET);
    wr(lvd_pkg::PDIR_OFS, 32'h0);
    wr(lvd_pkg::IRQ_OFS, 32'h0);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    chk("oe_n", 32'h1, PIN_OE_N);
    chk("on", 32'h0, DET_ENABLE);
    rc("ctrl", lvd_pkg::CTRL_OFS, 32'h0);
    rc("level", lvd_pkg::LEVEL_OFS, 32'h0);
    rc("pdir", lvd_pkg::PDIR_OFS, 32'hFF);
    rc("irq", lvd_pkg::IRQ_OFS, 32'h2);
    test_done;
  end
endmodule : lvd_ctrl_tb_top
